// File: shared/pssc_pkg.sv
// Shared constants and types for the pipelined synchronous static RAM core.
// Assumes both ends and the bus interface import this package.
package pssc_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 19;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int DATA_W = LANES * LANE_W;
	localparam int MEM_DEPTH = 1 << ADDR_W;
	localparam int BURST_W = 2;

	// ------------------------------------------------------------
	// Timing and reset values
	// ------------------------------------------------------------
	localparam logic [1:0] SLEEP_CYCLES = 2'h2;
	localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
	localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
	localparam logic [DATA_W-1:0] DATA_ZERO = 36'h0;
	localparam logic [DATA_W-1:0] BUS_IDLE = 36'hF_FFFF_FFFF;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 19'h0;
	localparam logic [LANES-1:0] LANES_OFF_N = 4'hF;

	// ------------------------------------------------------------
	// Pipeline stage contents
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_NONE = 3'h1,
		OP_READ = 3'h2,
		OP_WRITE = 3'h4
	} pssc_op_type;

endpackage

// File: shared/pssc_sram_if.sv
// Synchronous static RAM bus between the memory controller and the RAM.
// Assumes a single clock shared by both ends; the data wire rests high
// when neither end drives it.
interface pssc_sram_if;
	import pssc_pkg::*;

	// ------------------------------------------------------------
	// Synchronous control
	// ------------------------------------------------------------
	logic clock_gate_n;
	logic advance_load;
	logic write_n;
	logic chip_select_one_n;
	logic chip_select_two;
	logic chip_select_three_n;
	logic [LANES-1:0] lane_strobe_n;
	logic [ADDR_W-1:0] address;

	// ------------------------------------------------------------
	// Static and unclocked control
	// ------------------------------------------------------------
	logic output_enable_n;
	logic flow_mode_n;
	logic linear_order_n;
	logic sleep_request;

	// ------------------------------------------------------------
	// Data lanes, one byte lane per nine bits
	// ------------------------------------------------------------
	logic [DATA_W-1:0] dq_ctl;
	logic dq_ctl_oe_n;
	logic [DATA_W-1:0] dq_dev;
	logic dq_dev_oe_n;
	wire [DATA_W-1:0] dq;

	assign dq = !dq_ctl_oe_n ? dq_ctl : (!dq_dev_oe_n ? dq_dev : BUS_IDLE);

	modport dev (
		input clock_gate_n, advance_load, write_n, chip_select_one_n,
		input chip_select_two, chip_select_three_n, lane_strobe_n, address,
		input output_enable_n, flow_mode_n, linear_order_n, sleep_request,
		input dq,
		output dq_dev, dq_dev_oe_n
	);

	modport ctl (
		output clock_gate_n, advance_load, write_n, chip_select_one_n,
		output chip_select_two, chip_select_three_n, lane_strobe_n, address,
		output output_enable_n, flow_mode_n, linear_order_n, sleep_request,
		input dq,
		output dq_ctl, dq_ctl_oe_n
	);

endinterface

// File: rtl/pssc_burst_cnt.sv
// Two-bit burst address generator for the RAM end.
// Assumes load and advance are never high together and already carry the
// clock gate and sleep conditions.
module pssc_burst_cnt import pssc_pkg::*; (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Control
	input wire logic load_i,
	input wire logic advance_i,
	input wire logic linear_n_i,
	input wire logic [BURST_W-1:0] start_i,
	// Address low bits for the access taken on this edge
	output logic [BURST_W-1:0] addr_lo_o
);

	logic [BURST_W-1:0] start_q;
	logic [BURST_W-1:0] count_q;
	logic [BURST_W-1:0] count_d;
	logic [BURST_W-1:0] start_d;

	// ------------------------------------------------------------
	// Next count and sequence order
	// ------------------------------------------------------------
	assign start_d = load_i ? start_i : start_q;
	assign count_d = load_i ? BURST_ZERO :
		(advance_i ? count_q + BURST_STEP : count_q);
	assign addr_lo_o = linear_n_i ? (start_d ^ count_d) :
		(start_d + count_d);

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			start_q <= BURST_ZERO;
			count_q <= BURST_ZERO;
		end else begin
			start_q <= start_d;
			count_q <= count_d;
		end
	end

endmodule // pssc_burst_cnt

// File: rtl/pssc_sram_dev.sv
// RAM end: command pipeline, burst counter, storage array and data drivers.
// Assumes the controller presents every clocked pin synchronously to
// ref_clk_i and keeps the late-write data timing of the selected mode.
//
// Function
// - Clock gate high suspends all state except the sleep counter
// - Control pins sampled on rising clock edge
// - Controller loads new address with advance low
// - Selected only when all three selects asserted
// - Select two high active, one three low
// - Read loads address when selected, write high
// - Pipeline read data leaves output register next
// - Write registers address, strobes on select edge
// - Each low lane strobe writes its lane
// - No active strobes leaves memory unchanged
// - Pipeline write data on third edge
// - Flow-through read drives right after address
// - Flow-through write data on second edge
// - Reads turn to writes with no gap
// - Low address bits preset burst counter
// - Advance high uses next burst counter address
// - Mode select low chooses flow-through
// - Order select low chooses linear bursts
// - Sleep request high puts device asleep
// - Output enable high turns drivers off
// - Burst counter wraps after four accesses
// - Sleep after two cycles, state preserved
// - Drivers off automatically during write cycles
// - Stall keeps read driving, write undriven
module pssc_sram_dev import pssc_pkg::*; (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Memory bus
	pssc_sram_if.dev bus,
	// Status
	output logic sleeping_o
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [DATA_W-1:0] mem [MEM_DEPTH];
	logic [1:0] sleep_cnt_q;
	logic [1:0] sleep_cnt_d;
	logic sleeping;
	logic active;
	logic selected;
	logic load;
	logic advance;
	logic flow_mode;
	logic [BURST_W-1:0] addr_lo;
	pssc_op_type op1_q;
	pssc_op_type op1_d;
	pssc_op_type op2_q;
	logic [ADDR_W-1:0] addr1_q;
	logic [ADDR_W-1:0] addr1_d;
	logic [ADDR_W-1:0] addr2_q;
	logic [LANES-1:0] lanes1_n_q;
	logic [LANES-1:0] lanes2_n_q;
	logic [DATA_W-1:0] out_q;
	logic [DATA_W-1:0] flow_word;
	logic wr_go;
	logic [ADDR_W-1:0] wr_addr;
	logic [LANES-1:0] wr_lanes_n;
	logic drive;

	// ------------------------------------------------------------
	// Sleep control
	// ------------------------------------------------------------
	assign sleep_cnt_d = !bus.sleep_request ? 2'h0 :
		(sleep_cnt_q == SLEEP_CYCLES ? sleep_cnt_q :
		sleep_cnt_q + 2'h1);
	assign sleeping = sleep_cnt_q == SLEEP_CYCLES;
	assign sleeping_o = sleeping;

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			sleep_cnt_q <= 2'h0;
		end else begin
			sleep_cnt_q <= sleep_cnt_d;
		end
	end

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	assign active = !bus.clock_gate_n && !sleeping;
	assign selected = !bus.chip_select_one_n && bus.chip_select_two &&
		!bus.chip_select_three_n;
	assign load = active && !bus.advance_load;
	assign advance = active && bus.advance_load;
	assign flow_mode = !bus.flow_mode_n;

	always_comb begin
		op1_d = op1_q;
		if (load) begin
			if (!selected) begin
				op1_d = OP_NONE;
			end else if (bus.write_n) begin
				op1_d = OP_READ;
			end else begin
				op1_d = OP_WRITE;
			end
		end
	end

	// ------------------------------------------------------------
	// Burst address generation
	// ------------------------------------------------------------
	pssc_burst_cnt u_burst (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.load_i(load),
		.advance_i(advance),
		.linear_n_i(bus.linear_order_n),
		.start_i(bus.address[BURST_W-1:0]),
		.addr_lo_o(addr_lo)
	);

	assign addr1_d = {load ? bus.address[ADDR_W-1:BURST_W] :
		addr1_q[ADDR_W-1:BURST_W], addr_lo};

	// ------------------------------------------------------------
	// Command pipeline
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			op1_q <= OP_NONE;
			op2_q <= OP_NONE;
			addr1_q <= ADDR_ZERO;
			addr2_q <= ADDR_ZERO;
			lanes1_n_q <= LANES_OFF_N;
			lanes2_n_q <= LANES_OFF_N;
		end else if (active) begin
			op1_q <= op1_d;
			op2_q <= op1_q;
			addr1_q <= addr1_d;
			addr2_q <= addr1_q;
			lanes1_n_q <= bus.lane_strobe_n;
			lanes2_n_q <= lanes1_n_q;
		end
	end

	// ------------------------------------------------------------
	// Late write into the array
	// ------------------------------------------------------------
	assign wr_go = active &&
		(flow_mode ? op1_q == OP_WRITE : op2_q == OP_WRITE);
	assign wr_addr = flow_mode ? addr1_q : addr2_q;
	assign wr_lanes_n = flow_mode ? lanes1_n_q : lanes2_n_q;

	always_ff @(posedge ref_clk_i) begin
		for (int l = 0; l < LANES; l++) begin
			if (wr_go && !wr_lanes_n[l]) begin
				mem[wr_addr][l*LANE_W +: LANE_W] <= bus.dq[l*LANE_W +: LANE_W];
			end
		end
	end

	// ------------------------------------------------------------
	// Read path and output register
	// ------------------------------------------------------------
	assign flow_word = mem[addr1_q];

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			out_q <= DATA_ZERO;
		end else if (active && op1_q == OP_READ) begin
			out_q <= mem[addr1_q];
		end
	end

	// ------------------------------------------------------------
	// Data drivers
	// ------------------------------------------------------------
	assign drive = !bus.output_enable_n && !sleeping &&
		(flow_mode ? op1_q == OP_READ :
		op2_q == OP_READ);
	assign bus.dq_dev = flow_mode ? flow_word : out_q;
	assign bus.dq_dev_oe_n = !drive;

endmodule // pssc_sram_dev

// File: rtl/pssc_sram_ctl.sv
// Controller end: turns user commands into RAM bus cycles and returns reads.
// Assumes the user keeps cmd_valid_i low while hold_i or sleep_i is high
// and holds flow_mode_i, linear_order_i steady during traffic.
module pssc_sram_ctl import pssc_pkg::*; (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Memory bus
	pssc_sram_if.ctl bus,
	// Command port
	input wire logic cmd_valid_i,
	input wire logic cmd_write_i,
	input wire logic cmd_burst_i,
	input wire logic [ADDR_W-1:0] cmd_addr_i,
	input wire logic [DATA_W-1:0] cmd_wdata_i,
	input wire logic [LANES-1:0] cmd_lanes_i,
	output logic cmd_ready_o,
	// Read return
	output logic [DATA_W-1:0] rd_data_o,
	output logic rd_valid_o,
	// Static control
	input wire logic hold_i,
	input wire logic sleep_i,
	input wire logic flow_mode_i,
	input wire logic linear_order_i,
	input wire logic out_disable_i
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic gate_n_q, adv_q, write_n_q, cs1_n_q, cs2_q, cs3_n_q, sleep_q;
	logic oe_n_q, flow_n_q, lin_n_q, dq_oe_n_q, take, stepping;
	logic [LANES-1:0] lanes_n_q;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] wd0_q, d1_q, dq_q;
	logic [1:0] sleep_cnt_q;
	pssc_op_type pin_op, c1_q, c2_q;

	// ------------------------------------------------------------
	// Mirror of the RAM pipeline
	// ------------------------------------------------------------
	assign cmd_ready_o = !hold_i && !sleep_i;
	assign take = cmd_valid_i && cmd_ready_o;
	assign stepping = !gate_n_q && sleep_cnt_q != SLEEP_CYCLES;
	assign pin_op = adv_q ? c1_q : ((cs1_n_q || !cs2_q || cs3_n_q) ? OP_NONE :
		(write_n_q ? OP_READ : OP_WRITE));

	assign bus.clock_gate_n = gate_n_q;
	assign bus.advance_load = adv_q;
	assign bus.write_n = write_n_q;
	assign bus.chip_select_one_n = cs1_n_q;
	assign bus.chip_select_two = cs2_q;
	assign bus.chip_select_three_n = cs3_n_q;
	assign bus.lane_strobe_n = lanes_n_q;
	assign bus.address = addr_q;
	assign bus.output_enable_n = oe_n_q;
	assign bus.flow_mode_n = flow_n_q;
	assign bus.linear_order_n = lin_n_q;
	assign bus.sleep_request = sleep_q;
	assign bus.dq_ctl = dq_q;
	assign bus.dq_ctl_oe_n = dq_oe_n_q;

	// ------------------------------------------------------------
	// Pin registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			gate_n_q <= 1'b0;
			adv_q <= 1'b0;
			write_n_q <= 1'b1;
			{cs1_n_q, cs2_q, cs3_n_q} <= 3'h5;
			lanes_n_q <= LANES_OFF_N;
			addr_q <= ADDR_ZERO;
			wd0_q <= DATA_ZERO;
			{oe_n_q, flow_n_q, lin_n_q, sleep_q} <= 4'hC;
			sleep_cnt_q <= 2'h0;
		end else begin
			gate_n_q <= hold_i;
			oe_n_q <= out_disable_i;
			flow_n_q <= !flow_mode_i;
			lin_n_q <= !linear_order_i;
			sleep_q <= sleep_i;
			sleep_cnt_q <= !sleep_q ? 2'h0 :
				(sleep_cnt_q == SLEEP_CYCLES ? sleep_cnt_q : sleep_cnt_q + 2'h1);
			adv_q <= take && cmd_burst_i;
			{cs1_n_q, cs2_q, cs3_n_q} <= take ? 3'h2 : 3'h5;
			write_n_q <= !(take && cmd_write_i);
			lanes_n_q <= take ? ~cmd_lanes_i : LANES_OFF_N;
			if (take) begin
				addr_q <= cmd_addr_i;
				wd0_q <= cmd_wdata_i;
			end
		end
	end

	// ------------------------------------------------------------
	// Late write data and read capture
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			c1_q <= OP_NONE;
			c2_q <= OP_NONE;
			d1_q <= DATA_ZERO;
			dq_q <= DATA_ZERO;
			dq_oe_n_q <= 1'b1;
			rd_data_o <= DATA_ZERO;
			rd_valid_o <= 1'b0;
		end else begin
			rd_valid_o <= 1'b0;
			if (stepping) begin
				c1_q <= pin_op;
				c2_q <= c1_q;
				d1_q <= wd0_q;
				dq_q <= flow_n_q ? d1_q : wd0_q;
				dq_oe_n_q <= flow_n_q ? c1_q != OP_WRITE : pin_op != OP_WRITE;
				if (flow_n_q ? c2_q == OP_READ : c1_q == OP_READ) begin
					rd_data_o <= bus.dq;
					rd_valid_o <= 1'b1;
				end
			end
		end
	end

endmodule // pssc_sram_ctl

// File: dv/pssc_properties.sv
// Concurrent checks on the bus between the controller and the RAM end.
// Assumes one clock, a synchronous active-high reset and the bus signals
// handed in by name from the interface instance.
module pssc_properties import pssc_pkg::*; (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Synchronous control
	input wire logic clock_gate_n,
	input wire logic advance_load,
	input wire logic write_n,
	input wire logic chip_select_one_n,
	input wire logic chip_select_two,
	input wire logic chip_select_three_n,
	input wire logic [LANES-1:0] lane_strobe_n,
	// Static control
	input wire logic output_enable_n,
	input wire logic flow_mode_n,
	input wire logic sleep_request,
	// Data drivers
	input wire logic dq_ctl_oe_n,
	input wire logic [DATA_W-1:0] dq_dev,
	input wire logic dq_dev_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Decoded commands
	// ----------------------------------------------------------------
	logic slept_q;
	wire sel = !chip_select_one_n && chip_select_two && !chip_select_three_n;
	wire take = !clock_gate_n && !sleep_request && !slept_q;
	wire rd_take = take && sel && !advance_load && write_n;
	wire wr_take = take && sel && !advance_load && !write_n;
	wire some_lane = lane_strobe_n != 4'hF;

	always_ff @(posedge ref_clk_i) begin
		slept_q <= reset_i ? 1'b0 : sleep_request;
	end

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_oe_forces_off: assert property (
		output_enable_n |-> dq_dev_oe_n) else $error("RAM drives with oe high");
	a_sleep_drivers_off: assert property (
		sleep_request [*3] |-> dq_dev_oe_n) else $error("RAM drives asleep");
	a_no_bus_fight: assert property (
		!(!dq_ctl_oe_n && !dq_dev_oe_n)) else $error("both ends drive");
	a_pipe_read_late: assert property (
		rd_take && flow_mode_n ##1 !clock_gate_n |=>
		output_enable_n || !dq_dev_oe_n) else $error("pipeline read late");
	a_flow_read_late: assert property (
		rd_take && !flow_mode_n |=> output_enable_n || !dq_dev_oe_n)
		else $error("flow read late");
	a_pipe_write_data: assert property (
		wr_take && flow_mode_n && some_lane ##1 !clock_gate_n |=>
		!dq_ctl_oe_n && dq_dev_oe_n) else $error("pipeline write data");
	a_flow_write_data: assert property (
		wr_take && !flow_mode_n && some_lane |=> !dq_ctl_oe_n && dq_dev_oe_n)
		else $error("flow write data");
	a_stall_holds_read: assert property (
		!dq_dev_oe_n && clock_gate_n && !sleep_request |=>
		output_enable_n || (!dq_dev_oe_n && $stable(dq_dev)))
		else $error("stall lost read data");
	a_deselect_quiet: assert property (
		take && !advance_load && !sel && !flow_mode_n |=> dq_dev_oe_n)
		else $error("RAM drives when deselected");

	c_pipe_read: cover property (rd_take && flow_mode_n);
	c_write_abort: cover property (wr_take && !some_lane);
	c_stall_read: cover property (clock_gate_n && !dq_dev_oe_n);
	c_sleep: cover property (sleep_request [*3]);
endmodule // pssc_properties

// File: dv/pipelined_sync_sram_core_bench.sv
// Self-checking bench: both ends joined by the bus interface.
// Assumes the controller command and static control ports as the only stimulus points.
module pipelined_sync_sram_core_bench;
	import pssc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic ref_clk_i = 1'b0, reset_i = 1'b1, cmd_valid = 1'b0;
	logic cmd_write = 1'b0, cmd_burst = 1'b0, hold = 1'b0, sleep = 1'b0;
	logic flow = 1'b0, lin = 1'b1, odis = 1'b0;
	logic [ADDR_W-1:0] cmd_addr = ADDR_ZERO;
	logic [DATA_W-1:0] cmd_wdata = DATA_ZERO;
	logic [LANES-1:0] cmd_lanes = 4'h0;
	logic [DATA_W-1:0] rd_data;
	logic cmd_ready, rd_valid, sleeping;
	int fails = 0, comparisons = 0, cycles = 0;
	logic [DATA_W-1:0] mem [int];
	logic [DATA_W-1:0] exp_q [$];

	pssc_sram_if b ();
	pssc_sram_dev pssc_sram_dev_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
		.bus(b.dev), .sleeping_o(sleeping));
	pssc_sram_ctl pssc_sram_ctl_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
		.bus(b.ctl), .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write),
		.cmd_burst_i(cmd_burst), .cmd_addr_i(cmd_addr),
		.cmd_wdata_i(cmd_wdata), .cmd_lanes_i(cmd_lanes),
		.cmd_ready_o(cmd_ready), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
		.hold_i(hold), .sleep_i(sleep), .flow_mode_i(flow),
		.linear_order_i(lin), .out_disable_i(odis));
	pssc_properties pssc_properties_i (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.clock_gate_n(b.clock_gate_n),
		.advance_load(b.advance_load),
		.write_n(b.write_n),
		.chip_select_one_n(b.chip_select_one_n),
		.chip_select_two(b.chip_select_two),
		.chip_select_three_n(b.chip_select_three_n),
		.lane_strobe_n(b.lane_strobe_n),
		.output_enable_n(b.output_enable_n),
		.flow_mode_n(b.flow_mode_n),
		.sleep_request(b.sleep_request),
		.dq_ctl_oe_n(b.dq_ctl_oe_n),
		.dq_dev(b.dq_dev),
		.dq_dev_oe_n(b.dq_dev_oe_n)
	);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input string nm, input logic [DATA_W-1:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	function automatic logic [DATA_W-1:0] pat(input int k);
		return {9'(k + 3), 9'(k + 2), 9'(k + 1), 9'(k)};
	endfunction

	task automatic issue(input logic w, bst, input int a,
		input logic [DATA_W-1:0] d, input logic [LANES-1:0] ln);
		@(posedge ref_clk_i);
		cmd_valid <= 1'b1;
		cmd_write <= w;
		cmd_burst <= bst;
		cmd_addr <= a[ADDR_W-1:0];
		cmd_wdata <= d;
		cmd_lanes <= ln;
	endtask

	task automatic wr(input int a, input int k, input logic [LANES-1:0] ln);
		for (int l = 0; l < LANES; l++) begin
			if (ln[l]) mem[a][l*LANE_W +: LANE_W] = pat(k)[l*LANE_W +: LANE_W];
		end
		issue(1'b1, 1'b0, a, pat(k), ln);
	endtask

	task automatic rd(input int a, input logic bst);
		exp_q.push_back(mem[a]);
		issue(1'b0, bst, a, DATA_ZERO, 4'h0);
	endtask

	task automatic idle(input int n);
		@(posedge ref_clk_i);
		cmd_valid <= 1'b0;
		repeat (n) @(posedge ref_clk_i);
	endtask

	// ----------------------------------------------------------------
	// Clock, read monitor and timeout
	// ----------------------------------------------------------------
	initial begin
		forever #2 ref_clk_i = ~ref_clk_i;
	end

	always @(posedge ref_clk_i) begin
		cycles++;
		if (rd_valid === 1'b1) begin
			check("read data", rd_data, exp_q.size() ? exp_q.pop_front() : 'x);
		end
		if (cycles == 20000) begin
			fails++;
			print_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		for (int m = 0; m < 4; m++) begin
			idle(6);
			flow <= m[0];
			lin <= m[1];
			idle(6);
			for (int i = 0; i < 4; i++) wr(m * 16 + i, m * 16 + i, 4'hF);
			rd(m * 16, 1'b0);
			wr(m * 16 + 1, 100 + m, 4'h5);
			wr(m * 16 + 2, 200 + m, 4'h0);
			rd(m * 16 + 1, 1'b0);
			rd(m * 16 + 2, 1'b0);
			rd(m * 16 + 3, 1'b0);
			idle(flow ? 0 : 1);
			hold <= 1'b1;
			repeat (2) @(posedge ref_clk_i);
			@(negedge ref_clk_i);
			check("ready", cmd_ready, 1'b0);
			@(posedge ref_clk_i);
			hold <= 1'b0;
			rd(m * 16 + 2, 1'b0);
			for (int n = 1; n < 5; n++) begin
				rd(m * 16 + (lin ? (2 + n) % 4 : 2 ^ (n % 4)), 1'b1);
			end
			idle(8);
		end
		wr(70, 70, 4'hF);
		@(posedge ref_clk_i);
		cmd_valid <= 1'b0;
		sleep <= 1'b1;
		repeat (6) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		check("asleep", sleeping, 1'b1);
		@(posedge ref_clk_i);
		sleep <= 1'b0;
		idle(6);
		@(negedge ref_clk_i);
		check("awake", sleeping, 1'b0);
		rd(70, 1'b0);
		idle(8);
		odis <= 1'b1;
		exp_q.push_back(BUS_IDLE);
		issue(1'b0, 1'b0, 0, DATA_ZERO, 4'h0);
		idle(0);
		repeat (5) begin
			@(negedge ref_clk_i);
			check("device drive", b.dq_dev_oe_n, 1'b1);
		end
		idle(8);
		check("reads left", exp_q.size(), DATA_ZERO);
		print_verdict();
	end
endmodule // pipelined_sync_sram_core_bench
